/* File: core/asp_pkg.sv */
// Shared constants, types and helpers for both ends of the serial audio link.
package asp_pkg;
	typedef enum logic [1:0] {ASP_FMT_LJ, ASP_FMT_I2S, ASP_FMT_TDM} asp_fmt_t;
	typedef enum logic [1:0] {ASP_W16, ASP_W18, ASP_W20, ASP_W24} asp_width_t;

	localparam int ASP_MCLK_NS = 50;
	localparam int ASP_BCLK_NS = 400;
	localparam int ASP_DIV_CNT = ASP_BCLK_NS / ASP_MCLK_NS;
	localparam logic [2:0] ASP_DIV_LAST = 3'(ASP_DIV_CNT - 1);
	localparam logic [2:0] ASP_DIV_HALF = 3'(ASP_DIV_CNT / 2);
	// Two cycles of input synchroniser lag past the rising edge.
	localparam logic [2:0] ASP_DIV_SAMPLE = 3'(ASP_DIV_CNT / 2 + 2);

	localparam int ASP_SLOT_BITS = 32;
	localparam int ASP_SAMPLE_BITS = 24;
	localparam int ASP_PAD_BITS = 8;
	localparam int ASP_TDM_SLOTS = 8;
	localparam int ASP_CH = 4;
	localparam logic [7:0] ASP_LAST_2CH = 8'h3f;
	localparam logic [7:0] ASP_LAST_TDM = 8'hff;
	localparam logic [4:0] ASP_POS_LAST = 5'h1f;
	localparam logic [7:0] ASP_FCNT_RST = 8'hff;
	localparam logic [ASP_PAD_BITS-1:0] ASP_PAD_ZERO = 8'h00;

	function automatic logic [4:0] asp_delay(input asp_fmt_t fmt);
		return (fmt == ASP_FMT_I2S) ? 5'h01 : 5'h00;
	endfunction : asp_delay

	function automatic logic [7:0] asp_last(input asp_fmt_t fmt);
		return (fmt == ASP_FMT_TDM) ? ASP_LAST_TDM : ASP_LAST_2CH;
	endfunction : asp_last

	function automatic logic [23:0] asp_mask(input asp_width_t w);
		unique case (w)
			ASP_W16: return 24'hffff00;
			ASP_W18: return 24'hffffc0;
			ASP_W20: return 24'hfffff0;
			ASP_W24: return 24'hffffff;
		endcase
	endfunction : asp_mask

	// True on the bit that completes a received word.
	function automatic logic asp_rx_done(input asp_fmt_t fmt, input logic [4:0] pos);
		return (fmt == ASP_FMT_I2S) ? (pos == 5'h00) : (pos == ASP_POS_LAST);
	endfunction : asp_rx_done
endpackage : asp_pkg

/* File: core/asp_link_if.sv */
// Serial audio link between the codec end and the host end.
`timescale 1ns/1ps
`default_nettype none
interface asp_link_if;
	logic bclk;
	logic frame_word_clock;
	logic adc_serial_out_a;
	logic adc_serial_out_b;
	logic dac_serial_in_a;
	logic dac_serial_in_b;

	modport dev (
		output bclk,
		output frame_word_clock,
		output adc_serial_out_a,
		output adc_serial_out_b,
		input dac_serial_in_a,
		input dac_serial_in_b
	);
	modport host (
		input bclk,
		input frame_word_clock,
		input adc_serial_out_a,
		input adc_serial_out_b,
		output dac_serial_in_a,
		output dac_serial_in_b
	);
endinterface : asp_link_if
`default_nettype wire

/* File: core/asp_device.sv */
// Codec end of the serial audio link, acting as clock master.
`timescale 1ns/1ps
`default_nettype none
module asp_device
	import asp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire asp_fmt_t fmt_i,
	input wire asp_width_t width_i,
	input wire logic output_chain_enable_i,
	input wire logic [ASP_SAMPLE_BITS-1:0] analog_in_ch_i [ASP_CH],
	output logic [ASP_SAMPLE_BITS-1:0] analog_out_ch_o [ASP_CH],
	output logic frame_start_o,
	asp_link_if.dev link
);
	// Only clock master operation is built; the far end follows these clocks.
	// The fixed divider means the bit clock period is always eight system clocks.

	logic [2:0] div_r, div_nxt;
	logic bclk_r, bclk_nxt;
	logic [7:0] fcnt_r, fcnt_nxt;
	logic fwc_r, fwc_nxt;
	logic frame_start_nxt;
	logic fall, smp;
	logic [4:0] dly;

	// Bit clock divider and frame position.
	// The bit clock is high for the second half of the divider count, so every
	// bit clock edge falls on a known count.
	// After reset the frame counter rests on its last value, so the first
	// falling bit clock edge opens frame bit zero.
	always_comb begin
		fall = (div_r == ASP_DIV_LAST);
		smp = (div_r == ASP_DIV_SAMPLE);
		dly = asp_delay(fmt_i);
		div_nxt = fall ? 3'h0 : 3'(div_r + 3'h1);
		bclk_nxt = (div_nxt >= ASP_DIV_HALF);
		fcnt_nxt = fcnt_r;
		fwc_nxt = fwc_r;
		frame_start_nxt = 1'b0;
		if (fall) begin
			fcnt_nxt = (fcnt_r >= asp_last(fmt_i)) ? 8'h00 : 8'(fcnt_r + 8'h01);
			frame_start_nxt = (fcnt_nxt == 8'h00);
			unique case (fmt_i)
				ASP_FMT_I2S: fwc_nxt = fcnt_nxt[5];
				// A one bit wide pulse marks the start of a TDM frame.
				ASP_FMT_TDM: fwc_nxt = (fcnt_nxt == 8'h00);
				default: fwc_nxt = ~fcnt_nxt[5];
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_r <= 3'h0;
			bclk_r <= 1'b0;
			fcnt_r <= ASP_FCNT_RST;
			fwc_r <= 1'b0;
			frame_start_o <= 1'b0;
		end else begin
			div_r <= div_nxt;
			bclk_r <= bclk_nxt;
			fcnt_r <= fcnt_nxt;
			fwc_r <= fwc_nxt;
			frame_start_o <= frame_start_nxt;
		end
	end

	// Transmit shifters for both serial outputs.
	// They shift on the count that also drops the bit clock, so a data bit
	// and the falling edge leave their flops at the same clock edge.
	// The chain buffer refills every TDM frame whatever the enable says; the
	// enable only chooses what goes out in the upper four slots.
	logic [ASP_SLOT_BITS-1:0] sh_a_r, sh_a_nxt, sh_b_r, sh_b_nxt;
	logic [ASP_SAMPLE_BITS-1:0] chain_r [ASP_CH];
	logic [ASP_SAMPLE_BITS-1:0] chain_nxt [ASP_CH];
	logic [2:0] tslot;
	logic [23:0] msk;

	always_comb begin
		tslot = fcnt_nxt[7:5];
		msk = asp_mask(width_i);
		sh_a_nxt = sh_a_r;
		sh_b_nxt = sh_b_r;
		if (fall) begin
			sh_a_nxt = {sh_a_r[ASP_SLOT_BITS-2:0], 1'b0};
			sh_b_nxt = {sh_b_r[ASP_SLOT_BITS-2:0], 1'b0};
			if (fcnt_nxt[4:0] == dly) begin
				if (fmt_i == ASP_FMT_TDM) begin
					// Out B stays silent in TDM; the whole stream is on out A.
					sh_b_nxt = '0;
					if (tslot < 3'(ASP_CH)) begin
						// merged stream, slots in order, zero pad
						sh_a_nxt = {analog_in_ch_i[tslot[1:0]], ASP_PAD_ZERO};
					end else if (output_chain_enable_i) begin
						// chain gated, forward in B slots
						sh_a_nxt = {chain_r[tslot[1:0]], ASP_PAD_ZERO};
					end else begin
						sh_a_nxt = '0;
					end
				end else begin
					// Bits below the chosen word width go out as zero.
					// pair routing, ADC width mask
					sh_a_nxt = {analog_in_ch_i[{1'b0, tslot[0]}] & msk, ASP_PAD_ZERO};
					sh_b_nxt = {analog_in_ch_i[{1'b1, tslot[0]}] & msk, ASP_PAD_ZERO};
				end
			end
		end
	end

	logic dout_a_r, dout_b_r;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sh_a_r <= '0;
			sh_b_r <= '0;
			dout_a_r <= 1'b0;
			dout_b_r <= 1'b0;
		end else begin
			sh_a_r <= sh_a_nxt;
			sh_b_r <= sh_b_nxt;
			dout_a_r <= sh_a_nxt[ASP_SLOT_BITS-1];
			dout_b_r <= sh_b_nxt[ASP_SLOT_BITS-1];
		end
	end

	assign link.bclk = bclk_r;
	assign link.frame_word_clock = fwc_r;
	assign link.adc_serial_out_a = dout_a_r;
	assign link.adc_serial_out_b = dout_b_r;

	// Receive path; serial inputs come from another domain.
	// A bit is taken two counts after the bit clock rises, when the second
	// synchroniser stage holds the value that stood just after that rise.
	// In I2S a word ends on the first bit of the next slot, so the slot
	// index is taken back by one there.
	logic [1:0] sync1_r, sync2_r;
	logic [ASP_SLOT_BITS-1:0] rx_a_r, rx_a_nxt, rx_b_r, rx_b_nxt;
	logic [ASP_SAMPLE_BITS-1:0] dac_nxt [ASP_CH];
	logic [2:0] rslot;

	always_comb begin
		rx_a_nxt = rx_a_r;
		rx_b_nxt = rx_b_r;
		dac_nxt = analog_out_ch_o;
		chain_nxt = chain_r;
		rslot = 3'(fcnt_r[7:5] - dly[2:0]);
		if (smp) begin
			rx_a_nxt = {rx_a_r[ASP_SLOT_BITS-2:0], sync2_r[0]};
			rx_b_nxt = {rx_b_r[ASP_SLOT_BITS-2:0], sync2_r[1]};
			if (asp_rx_done(fmt_i, fcnt_r[4:0])) begin
				if (fmt_i == ASP_FMT_TDM) begin
					if (rslot < 3'(ASP_CH)) begin
						// low 8 ignored, 24-bit DAC words
						dac_nxt[rslot[1:0]] = rx_a_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
						chain_nxt[rslot[1:0]] = rx_b_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
					end
				end else begin
					dac_nxt[{1'b0, rslot[0]}] = rx_a_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
					dac_nxt[{1'b1, rslot[0]}] = rx_b_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
			rx_a_r <= '0;
			rx_b_r <= '0;
			for (int i = 0; i < ASP_CH; i++) begin
				analog_out_ch_o[i] <= '0;
				chain_r[i] <= '0;
			end
		end else begin
			sync1_r <= {link.dac_serial_in_b, link.dac_serial_in_a};
			sync2_r <= sync1_r;
			rx_a_r <= rx_a_nxt;
			rx_b_r <= rx_b_nxt;
			analog_out_ch_o <= dac_nxt;
			chain_r <= chain_nxt;
		end
	end
endmodule : asp_device
`default_nettype wire

/* File: core/asp_host.sv */
// Host end of the serial audio link, slave to the codec's clocks.
`timescale 1ns/1ps
`default_nettype none
module asp_host
	import asp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire asp_fmt_t fmt_i,
	input wire logic [ASP_SAMPLE_BITS-1:0] tx_a_i [ASP_TDM_SLOTS],
	input wire logic [ASP_SAMPLE_BITS-1:0] tx_b_i [ASP_TDM_SLOTS],
	output logic [ASP_SAMPLE_BITS-1:0] rx_a_o [ASP_TDM_SLOTS],
	output logic [ASP_SAMPLE_BITS-1:0] rx_b_o [ASP_TDM_SLOTS],
	output logic frame_start_o,
	asp_link_if.host link
);
	// Bit order: 0 bit clock, 1 word clock, 2 out A, 3 out B.
	logic [3:0] sync1_r, sync2_r;
	logic bclk_d_r, fwc_d_r, fwc_d_nxt;
	logic rise, fall, start, frame_start_nxt;
	logic [7:0] cnt_r, cnt_nxt, nb;
	logic [4:0] dly;
	logic [2:0] rslot;
	logic [ASP_SLOT_BITS-1:0] sr_a_r, sr_a_nxt, sr_b_r, sr_b_nxt;
	logic [ASP_SLOT_BITS-1:0] st_a_r, st_a_nxt, st_b_r, st_b_nxt;
	logic [ASP_SAMPLE_BITS-1:0] rxa_nxt [ASP_TDM_SLOTS];
	logic [ASP_SAMPLE_BITS-1:0] rxb_nxt [ASP_TDM_SLOTS];

	always_comb begin
		rise = sync2_r[0] & ~bclk_d_r;
		fall = ~sync2_r[0] & bclk_d_r;
		dly = asp_delay(fmt_i);
		// LJ frame opens high, I2S frame opens low
		start = (sync2_r[1] != fwc_d_r) && (sync2_r[1] == (fmt_i != ASP_FMT_I2S));
		fwc_d_nxt = rise ? sync2_r[1] : fwc_d_r;
		frame_start_nxt = rise & start;
		cnt_nxt = cnt_r;
		sr_a_nxt = sr_a_r;
		sr_b_nxt = sr_b_r;
		st_a_nxt = st_a_r;
		st_b_nxt = st_b_r;
		rxa_nxt = rx_a_o;
		rxb_nxt = rx_b_o;
		rslot = 3'h0;
		nb = (cnt_r >= asp_last(fmt_i)) ? 8'h00 : 8'(cnt_r + 8'h01);
		if (rise) begin
			cnt_nxt = start ? 8'h00 : nb;
			rslot = 3'(cnt_nxt[7:5] - dly[2:0]);
			// codec data valid at rising edge
			sr_a_nxt = {sr_a_r[ASP_SLOT_BITS-2:0], sync2_r[2]};
			sr_b_nxt = {sr_b_r[ASP_SLOT_BITS-2:0], sync2_r[3]};
			if (asp_rx_done(fmt_i, cnt_nxt[4:0])) begin
				if (fmt_i == ASP_FMT_TDM) begin
					rxa_nxt[rslot] = sr_a_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
				end else begin
					rxa_nxt[{2'b00, rslot[0]}] = sr_a_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
					rxb_nxt[{2'b00, rslot[0]}] = sr_b_nxt[ASP_SLOT_BITS-1:ASP_PAD_BITS];
				end
			end
		end
		if (fall) begin
			// host bit stable before rising edge
			st_a_nxt = {st_a_r[ASP_SLOT_BITS-2:0], 1'b0};
			st_b_nxt = {st_b_r[ASP_SLOT_BITS-2:0], 1'b0};
			if (nb[4:0] == dly) begin
				if (fmt_i == ASP_FMT_TDM) begin
					st_a_nxt = {tx_a_i[nb[7:5]], ASP_PAD_ZERO};
					st_b_nxt = {tx_b_i[nb[7:5]], ASP_PAD_ZERO};
				end else begin
					st_a_nxt = {tx_a_i[{2'b00, nb[5]}], ASP_PAD_ZERO};
					st_b_nxt = {tx_b_i[{2'b00, nb[5]}], ASP_PAD_ZERO};
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			bclk_d_r <= 1'b0;
			fwc_d_r <= 1'b0;
			cnt_r <= ASP_FCNT_RST;
			sr_a_r <= '0;
			sr_b_r <= '0;
			st_a_r <= '0;
			st_b_r <= '0;
			frame_start_o <= 1'b0;
			for (int i = 0; i < ASP_TDM_SLOTS; i++) begin
				rx_a_o[i] <= '0;
				rx_b_o[i] <= '0;
			end
		end else begin
			sync1_r <= {link.adc_serial_out_b, link.adc_serial_out_a,
				link.frame_word_clock, link.bclk};
			sync2_r <= sync1_r;
			bclk_d_r <= sync2_r[0];
			fwc_d_r <= fwc_d_nxt;
			cnt_r <= cnt_nxt;
			sr_a_r <= sr_a_nxt;
			sr_b_r <= sr_b_nxt;
			st_a_r <= st_a_nxt;
			st_b_r <= st_b_nxt;
			frame_start_o <= frame_start_nxt;
			rx_a_o <= rxa_nxt;
			rx_b_o <= rxb_nxt;
		end
	end

	assign link.dac_serial_in_a = st_a_r[ASP_SLOT_BITS-1];
	assign link.dac_serial_in_b = st_b_r[ASP_SLOT_BITS-1];
endmodule : asp_host
`default_nettype wire

/* File: test/asp_link_assertions.sv */
// Timing checks on the wires of the serial audio link.
`timescale 1ns/1ps
`default_nettype none
module asp_link_assertions (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic bclk,
	input wire logic frame_word_clock,
	input wire logic adc_serial_out_a,
	input wire logic adc_serial_out_b,
	input wire logic dac_serial_in_a,
	input wire logic dac_serial_in_b
);
	logic fwc_d_r;
	logic seen_r;
	logic seen_nxt;
	logic [11:0] gap_r;
	logic [11:0] gap_nxt;
	logic chg;
	always_comb begin
		chg = frame_word_clock != fwc_d_r;
		seen_nxt = seen_r | chg;
		gap_nxt = chg ? 12'h000 : gap_r + 12'h001;
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fwc_d_r <= 1'b0;
			seen_r <= 1'b0;
			gap_r <= 12'h000;
		end else begin
			fwc_d_r <= frame_word_clock;
			seen_r <= seen_nxt;
			gap_r <= gap_nxt;
		end
	end
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_hi4;
		bclk [*4] ##1 !bclk;
	endsequence
	sequence s_lo4;
		!bclk [*4] ##1 bclk;
	endsequence
	a_bclk_high_time: assert property ($rose(bclk) |-> s_hi4)
		else $error("bit clock high time wrong");
	a_bclk_low_time: assert property ($fell(bclk) |-> s_lo4)
		else $error("bit clock low time wrong");
	a_out_a_edge: assert property ($changed(adc_serial_out_a) |-> $fell(bclk))
		else $error("out a moved off falling edge");
	a_out_b_edge: assert property ($changed(adc_serial_out_b) |-> $fell(bclk))
		else $error("out b moved off falling edge");
	a_word_clk_edge: assert property ($changed(frame_word_clock) |-> $fell(bclk))
		else $error("word clock moved off falling edge");
	a_slot_length: assert property (chg && seen_r |-> gap_r inside {12'h0ff, 12'h007, 12'h7f7})
		else $error("slot length wrong");
	a_in_a_hold: assert property ($rose(bclk) |-> $stable(dac_serial_in_a) [*2])
		else $error("in a moved at rising edge");
	a_in_b_hold: assert property ($rose(bclk) |-> $stable(dac_serial_in_b) [*2])
		else $error("in b moved at rising edge");
endmodule : asp_link_assertions
`default_nettype wire

/* File: test/audio_serial_port_formats_bench.sv */
// Bench joining both link ends in every format.
`timescale 1ns/1ps
`default_nettype none
module audio_serial_port_formats_bench
	import asp_pkg::*;
;
	logic mclk;
	logic nrst;
	asp_fmt_t fmt;
	asp_width_t wid;
	logic chain;
	logic [23:0] ain [4];
	logic [23:0] aout [4];
	logic [23:0] tx_a [8];
	logic [23:0] tx_b [8];
	logic [23:0] rx_a [8];
	logic [23:0] rx_b [8];
	logic hfs;
	logic dfs;
	int dper;
	logic [31:0] sr;
	logic [31:0] cap_l;
	logic [31:0] cap_r;
	logic fprev;
	int k;
	int bad_b;
	int n_errors;
	int samples_checked;
	asp_link_if link ();
	asp_device asp_device_inst (.mclk_i(mclk), .nrst_i(nrst), .fmt_i(fmt), .width_i(wid),
		.output_chain_enable_i(chain), .analog_in_ch_i(ain), .analog_out_ch_o(aout),
		.frame_start_o(dfs), .link(link));
	asp_host asp_host_inst (.mclk_i(mclk), .nrst_i(nrst), .fmt_i(fmt), .tx_a_i(tx_a),
		.tx_b_i(tx_b), .rx_a_o(rx_a), .rx_b_o(rx_b), .frame_start_o(hfs), .link(link));
	asp_link_assertions asp_link_assertions_inst (.mclk_i(mclk), .nrst_i(nrst),
		.bclk(link.bclk), .frame_word_clock(link.frame_word_clock),
		.adc_serial_out_a(link.adc_serial_out_a), .adc_serial_out_b(link.adc_serial_out_b),
		.dac_serial_in_a(link.dac_serial_in_a), .dac_serial_in_b(link.dac_serial_in_b));
	always #25 mclk = ~mclk;
	// wire words gathered at each rising bit clock.
	always @(posedge link.bclk) begin
		sr = {sr[30:0], link.adc_serial_out_a};
		if (fmt == ASP_FMT_TDM ? link.frame_word_clock && !fprev : link.frame_word_clock != fprev)
			k = 0;
		else
			k = k + 1;
		if (fmt == ASP_FMT_I2S ? k == 0 : k == 31) begin
			if (link.frame_word_clock || fmt == ASP_FMT_TDM)
				cap_l = sr;
			else
				cap_r = sr;
		end
		if (fmt == ASP_FMT_TDM && link.adc_serial_out_b !== 1'b0)
			bad_b++;
		fprev = link.frame_word_clock;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic frames(input int n);
		int f;
		int t;
		int tl;
		f = 0;
		t = 0;
		tl = 0;
		dper = 0;
		while (f < n && t < 20000) begin
			@(posedge mclk);
			t++;
			if (hfs === 1'b1)
				f++;
			if (dfs === 1'b1) begin
				dper = t - tl;
				tl = t;
			end
		end
		if (f < n) begin
			n_errors++;
			$display("unexpected at %0t: no frame start", $time);
			tally_and_finish();
		end
		@(negedge mclk);
	endtask : frames
	task automatic run(input asp_fmt_t f, input asp_width_t w, input logic c);
		logic [23:0] m;
		int fl;
		@(negedge mclk);
		nrst = 1'b0;
		fmt = f;
		wid = w;
		chain = c;
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		bad_b = 0;
		cap_l = 32'h00000000;
		cap_r = 32'h00000000;
		frames(4);
		fl = (f == ASP_FMT_TDM ? ASP_TDM_SLOTS : 2) * ASP_SLOT_BITS * ASP_DIV_CNT;
		chk(32'(dper), 32'(fl)); // frame length
		m = (f == ASP_FMT_TDM || w == ASP_W24) ? 24'hffffff : 24'hffffff << (8 - 2 * w);
		chk(cap_l, {ain[0] & m, 8'h00}); // left word on wire
		if (f == ASP_FMT_TDM) begin
			for (int i = 0; i < 8; i++)
				chk(32'(rx_a[i]), 32'(i < 4 ? ain[i] : (c ? tx_b[i - 4] : 24'h000000))); // slots
			for (int i = 0; i < 4; i++)
				chk(32'(aout[i]), 32'(tx_a[i])); // TDM in a slots
			chk(32'(bad_b), 32'h00000000); // out b quiet
		end else begin
			chk(cap_r, {ain[1] & m, 8'h00}); // right word on wire
			for (int i = 0; i < 2; i++) begin
				chk(32'(rx_a[i]), 32'(ain[i] & m)); // out a pair
				chk(32'(rx_b[i]), 32'(ain[i + 2] & m)); // out b pair
				chk(32'(aout[i]), 32'(tx_a[i])); // in a pair
				chk(32'(aout[i + 2]), 32'(tx_b[i])); // in b pair
			end
		end
		$display("test fmt %0d width %0d chain %0d done", f, w, c);
	endtask : run
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		fmt = ASP_FMT_LJ;
		wid = ASP_W24;
		chain = 1'b0;
		ain = '{24'h9a5c3f, 24'h5b1e7d, 24'hc3a781, 24'h6e2d4b};
		for (int i = 0; i < 8; i++) begin
			tx_a[i] = {4'ha, 4'(i), 16'h5a3c};
			tx_b[i] = {4'h3, 4'(i), 16'hc5e1};
		end
		sr = 32'h00000000;
		cap_l = 32'h00000000;
		cap_r = 32'h00000000;
		fprev = 1'b0;
		k = 0;
		bad_b = 0;
		n_errors = 0;
		samples_checked = 0;
		run(ASP_FMT_LJ, ASP_W16, 1'b0);
		run(ASP_FMT_LJ, ASP_W24, 1'b0);
		run(ASP_FMT_I2S, ASP_W18, 1'b0);
		run(ASP_FMT_I2S, ASP_W20, 1'b0);
		run(ASP_FMT_TDM, ASP_W24, 1'b0);
		run(ASP_FMT_TDM, ASP_W16, 1'b1);
		tally_and_finish();
	end
endmodule : audio_serial_port_formats_bench
`default_nettype wire
